/* hw/hcsr_regs.sv */
// Directly addressable system control and status register map of the host interface.
//
// Operation
// - Decode registers 050h-314h from host port.
// - Chip reset returns every register to default.
// - Unlisted offsets reserved; reads zero, writes ignored.
// - FIFO ranges 000h-01Ch (read), 020h-03Ch (write) each alias one FIFO.
// - Byte test invalid until interface reset done.
`include "hcsr_params.svh"
module hcsr_regs #(
  parameter int          HIF_RESET_CYCLES = `HCSR_HIF_RESET_CYCLES,
  parameter int          READY_CYCLES     = `HCSR_READY_CYCLES,
  parameter int          FIFO_AW          = 4,
  parameter logic [31:0] ID_VALUE         = `HCSR_ID_VALUE  // Arbitrary value.
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        host_req_in,
  input  wire logic        host_write_in,
  input  wire logic [9:0]  host_addr_in,
  input  wire logic [1:0]  host_size_in,
  input  wire logic [31:0] host_wdata_in,
  input  wire logic        pram_rd_push_in,
  input  wire logic [31:0] pram_rd_data_in,
  input  wire logic [31:0] int_event_in,
  output logic             host_rd_valid_out,
  output logic [31:0]      host_rdata_out,
  output logic             pram_wr_valid_out,
  output logic [31:0]      pram_wr_data_out,
  output logic             pram_rd_full_out
);
  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  localparam int RW_N = 12;
  localparam logic [3:0] RW_HARDWARE_CONFIG  = 4'h2;
  localparam logic [3:0] RW_PMT     = 4'h3;
  localparam logic [3:0] RW_TMR_CFG = 4'h4;
  localparam logic [9:0] RW_OFF [RW_N] = '{
    `HCSR_OFF_IRQ_CFG, `HCSR_OFF_INT_EN, `HCSR_OFF_HARDWARE_CONFIG, `HCSR_OFF_PWR_CTRL,
    `HCSR_OFF_TMR_CONFIG, `HCSR_OFF_RESET_CONTROL, `HCSR_OFF_CSR_DATA, `HCSR_OFF_CSR_CMD,
    `HCSR_OFF_RD_ADDR_LEN, `HCSR_OFF_RD_CMD, `HCSR_OFF_WR_ADDR_LEN, `HCSR_OFF_WR_CMD
  };

  function automatic logic [3:0] rw_index(input logic [9:0] w);
    logic [3:0] idx;
    idx = 4'(RW_N);
    for (int i = 0; i < RW_N; i++) begin
      if (w == RW_OFF[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  function automatic hcsr_pkg::hcsr_sel_t decode(input logic [9:0] w);
    hcsr_pkg::hcsr_sel_t s;
    s = hcsr_pkg::SEL_NONE;
    if (w <= `HCSR_OFF_RD_FIFO_HI) begin
      s = hcsr_pkg::SEL_RD_FIFO;
    end else if (w >= `HCSR_OFF_WR_FIFO_LO && w <= `HCSR_OFF_WR_FIFO_HI) begin
      s = hcsr_pkg::SEL_WR_FIFO;
    end else if (w == `HCSR_OFF_CHIP_IDENTITY_REVISION) begin
      s = hcsr_pkg::SEL_ID;
    end else if (w == `HCSR_OFF_INTR_STATUS) begin
      s = hcsr_pkg::SEL_INTR_STAT;
    end else if (w == `HCSR_OFF_BYTE_TEST) begin
      s = hcsr_pkg::SEL_BYTE_TEST;
    end else if (w == `HCSR_OFF_TMR_COUNT) begin
      s = hcsr_pkg::SEL_TMR_COUNT;
    end else if (w == `HCSR_OFF_FREE_RUN) begin
      s = hcsr_pkg::SEL_FREE_RUN;
    end else if (rw_index(w) != 4'(RW_N)) begin
      s = hcsr_pkg::SEL_RW;
    end
    return s;
  endfunction

  logic [9:0]          word_addr;
  hcsr_pkg::hcsr_sel_t sel;
  logic [3:0]          rw_idx;
  logic [2:0]          nbytes;
  logic                complete;
  logic [3:0]          lanes;
  logic                commit;
  logic                rd_done;

  assign word_addr = {host_addr_in[9:2], 2'b00};
  assign sel       = decode(word_addr);
  assign rw_idx    = rw_index(word_addr);
  assign nbytes    = (host_size_in == 2'h0) ? 3'h1 : (host_size_in == 2'h1) ? 3'h2 : 3'h4;
  assign complete  = ({1'b0, host_addr_in[1:0]} + nbytes) == 3'h4;
  assign lanes     = (host_size_in == 2'h0) ? (4'h1 << host_addr_in[1:0]) :
                     (host_size_in == 2'h1) ? (4'h3 << host_addr_in[1:0]) : 4'hF;
  assign commit    = host_req_in && host_write_in && complete;
  assign rd_done   = host_req_in && !host_write_in && complete;

  // ------------------------------------------------------------------
  // Piece assembly
  // ------------------------------------------------------------------
  logic [31:0] stage;
  logic [31:0] merged;

  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_lane
      assign merged[gl*8 +: 8] = lanes[gl] ? host_wdata_in[gl*8 +: 8] : stage[gl*8 +: 8];
    end
  endgenerate

  // Narrow pieces collect here; nothing reaches a register before the last one.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      stage <= `HCSR_RST_RW;
    end else if (host_req_in && host_write_in) begin
      stage <= merged;
    end
  end

  // ------------------------------------------------------------------
  // Reset sequencing
  // ------------------------------------------------------------------
  hcsr_pkg::hcsr_state_t state;
  logic [15:0]           seq_cnt;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state   <= hcsr_pkg::HS_RESET;
      seq_cnt <= 16'h0000;
    end else begin
      case (state)
        hcsr_pkg::HS_RESET: begin
          seq_cnt <= seq_cnt + 16'h0001;
          if (seq_cnt == 16'(HIF_RESET_CYCLES - 1)) begin
            state   <= hcsr_pkg::HS_HIF_UP;
            seq_cnt <= 16'h0000;
          end
        end
        hcsr_pkg::HS_HIF_UP: begin
          seq_cnt <= seq_cnt + 16'h0001;
          if (seq_cnt == 16'(READY_CYCLES - 1)) begin
            state <= hcsr_pkg::HS_READY;
          end
        end
        hcsr_pkg::HS_READY: state <= hcsr_pkg::HS_READY;
        default: state <= hcsr_pkg::HS_RESET;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Plain read/write registers
  // ------------------------------------------------------------------
  logic [31:0] rw_q [RW_N];

  genvar gr;
  generate
    for (gr = 0; gr < RW_N; gr++) begin : g_rw
      always_ff @(posedge mclk_in) begin
        if (rst_in) begin
          rw_q[gr] <= `HCSR_RST_RW;
        end else if (commit && sel == hcsr_pkg::SEL_RW && rw_idx == 4'(gr)) begin
          rw_q[gr] <= merged;
        end
      end
    end
  endgenerate

  // Write-one-to-clear; a new event in the clearing cycle survives.
  logic [31:0] intr_status;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      intr_status <= `HCSR_RST_INTR_STATUS;
    end else if (commit && sel == hcsr_pkg::SEL_INTR_STAT) begin
      intr_status <= (intr_status & ~merged) | int_event_in;
    end else begin
      intr_status <= intr_status | int_event_in;
    end
  end

  // ------------------------------------------------------------------
  // Counters
  // ------------------------------------------------------------------
  localparam logic [7:0] TICK_LAST = 8'(`HCSR_TICK_CYCLES - 1);
  logic [7:0]  tick_div;
  logic        tick;
  logic [31:0] free_run;
  logic [31:0] tmr_count;

  assign tick = tick_div == TICK_LAST;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tick_div <= 8'h00;
      free_run <= `HCSR_RST_COUNT;
    end else begin
      tick_div <= tick ? 8'h00 : tick_div + 8'h01;
      free_run <= tick ? free_run + 32'h0000_0001 : free_run;
    end
  end

  // The timer reloads from the configured value and wraps; rewriting the
  // configuration restarts it so software sees a fresh count.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tmr_count <= `HCSR_RST_COUNT;
    end else if (commit && sel == hcsr_pkg::SEL_RW && rw_idx == RW_TMR_CFG) begin
      tmr_count <= {16'h0000, merged[`HCSR_GPT_LOAD_MSB:0]};
    end else if (commit && sel == hcsr_pkg::SEL_TMR_COUNT) begin
      tmr_count <= merged;
    end else if (rw_q[RW_TMR_CFG][`HCSR_GPT_EN_BIT] && tick) begin
      tmr_count <= (tmr_count == 32'h0000_0000) ?
                   {16'h0000, rw_q[RW_TMR_CFG][`HCSR_GPT_LOAD_MSB:0]} :
                   tmr_count - 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------------
  // Process RAM FIFOs
  // ------------------------------------------------------------------
  hcsr_mem_if #(.W(32), .AW(FIFO_AW)) mem_bus ();

  logic [FIFO_AW:0] wr_ptr;
  logic [FIFO_AW:0] rd_ptr;
  logic [FIFO_AW:0] next_wr_ptr;
  logic [FIFO_AW:0] next_rd_ptr;
  logic             push;
  logic             pop;

  assign push = pram_rd_push_in && !pram_rd_full_out;
  assign pop  = rd_done && sel == hcsr_pkg::SEL_RD_FIFO && (wr_ptr != rd_ptr);

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wr_ptr           <= '0;
      rd_ptr           <= '0;
      pram_rd_full_out <= 1'b0;
    end else begin
      wr_ptr           <= next_wr_ptr;
      rd_ptr           <= next_rd_ptr;
      pram_rd_full_out <= (next_wr_ptr[FIFO_AW] != next_rd_ptr[FIFO_AW]) &&
                          (next_wr_ptr[FIFO_AW-1:0] == next_rd_ptr[FIFO_AW-1:0]);
    end
  end

  assign mem_bus.wr_en   = push;
  assign mem_bus.wr_addr = wr_ptr[FIFO_AW-1:0];
  assign mem_bus.wr_data = pram_rd_data_in;
  assign mem_bus.rd_addr = rd_ptr[FIFO_AW-1:0];

  hcsr_fifo_mem #(.W(32), .AW(FIFO_AW)) u_mem (
    .mclk_in (mclk_in),
    .port    (mem_bus.mem)
  );

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pram_wr_valid_out <= 1'b0;
      pram_wr_data_out  <= `HCSR_RST_RW;
    end else begin
      pram_wr_valid_out <= commit && sel == hcsr_pkg::SEL_WR_FIFO;
      pram_wr_data_out  <= merged;
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  logic [31:0] live;
  logic [31:0] snap;
  logic        ready;

  assign ready = state == hcsr_pkg::HS_READY;

  always_comb begin
    live = 32'h0000_0000;
    case (sel)
      hcsr_pkg::SEL_RD_FIFO:   live = mem_bus.rd_data;
      hcsr_pkg::SEL_ID:        live = ID_VALUE;
      hcsr_pkg::SEL_INTR_STAT: live = intr_status;
      hcsr_pkg::SEL_BYTE_TEST: live = (state == hcsr_pkg::HS_RESET) ?
                                      `HCSR_BYTE_TEST_BAD : `HCSR_BYTE_TEST_GOOD;
      hcsr_pkg::SEL_TMR_COUNT: live = tmr_count;
      hcsr_pkg::SEL_FREE_RUN:  live = free_run;
      hcsr_pkg::SEL_RW: begin
        live = rw_q[rw_idx];
        if (rw_idx == RW_HARDWARE_CONFIG) begin
          live[`HCSR_HW_READY_BIT] = ready;
        end
        if (rw_idx == RW_PMT) begin
          live[`HCSR_PMT_READY_BIT] = ready;
        end
      end
      default: live = 32'h0000_0000;
    endcase
  end

  // The first piece of a narrow read freezes the word so later pieces match it.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      snap              <= `HCSR_RST_RW;
      host_rd_valid_out <= 1'b0;
      host_rdata_out    <= `HCSR_RST_RW;
    end else begin
      host_rd_valid_out <= host_req_in && !host_write_in;
      if (host_req_in && !host_write_in) begin
        if (host_addr_in[1:0] == 2'h0) begin
          snap           <= live;
          host_rdata_out <= live;
        end else begin
          host_rdata_out <= snap;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  read_answer_a: assert property (host_req_in && !host_write_in |=> host_rd_valid_out)
    else $error("read request got no answer");
  reserved_zero_a: assert property (host_req_in && !host_write_in &&
      host_addr_in[1:0] == 2'h0 && sel == hcsr_pkg::SEL_NONE |=> host_rdata_out == 32'h0)
    else $error("reserved offset read nonzero");
  byte_bad_a: assert property (host_req_in && !host_write_in &&
      host_addr_in == `HCSR_OFF_BYTE_TEST && state == hcsr_pkg::HS_RESET
      |=> host_rdata_out == `HCSR_BYTE_TEST_BAD)
    else $error("byte test valid too early");
  byte_good_a: assert property (host_req_in && !host_write_in &&
      host_addr_in == `HCSR_OFF_BYTE_TEST && ready |=> host_rdata_out == `HCSR_BYTE_TEST_GOOD)
    else $error("byte test pattern wrong");
  wr_fifo_alias_a: assert property (commit && word_addr >= `HCSR_OFF_WR_FIFO_LO &&
      word_addr <= `HCSR_OFF_WR_FIFO_HI |=> pram_wr_valid_out && pram_wr_data_out == $past(merged))
    else $error("write FIFO alias missed");
  rd_fifo_pop_a: assert property (rd_done && word_addr <= `HCSR_OFF_RD_FIFO_HI &&
      wr_ptr != rd_ptr |=> rd_ptr == $past(rd_ptr) + 1'b1)
    else $error("read FIFO alias did not pop");
  partial_hold_a: assert property (host_req_in && host_write_in && !complete &&
      word_addr == `HCSR_OFF_INT_EN |=> $stable(rw_q[1]))
    else $error("partial write changed register");
  commit_write_a: assert property (commit && word_addr == `HCSR_OFF_INT_EN
      |=> rw_q[1] == $past(merged))
    else $error("completing write not stored");
  reset_default_a: assert property (disable iff (1'b0)
      rst_in |=> intr_status == `HCSR_RST_INTR_STATUS && rw_q[0] == `HCSR_RST_RW &&
      !host_rd_valid_out)
    else $error("reset default not restored");
endmodule

/* hw/hcsr_params.svh */
// Offsets, field positions, reset values and timing counts of the host register map.
`ifndef HCSR_PARAMS_SVH
`define HCSR_PARAMS_SVH

// ------------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------------
`define HCSR_OFF_RD_FIFO_LO   10'h000
`define HCSR_OFF_RD_FIFO_HI   10'h01C
`define HCSR_OFF_WR_FIFO_LO   10'h020
`define HCSR_OFF_WR_FIFO_HI   10'h03C
`define HCSR_OFF_CHIP_IDENTITY_REVISION       10'h050
`define HCSR_OFF_IRQ_CFG      10'h054
`define HCSR_OFF_INTR_STATUS  10'h058
`define HCSR_OFF_INT_EN       10'h05C
`define HCSR_OFF_BYTE_TEST    10'h064
`define HCSR_OFF_HARDWARE_CONFIG       10'h074
`define HCSR_OFF_PWR_CTRL     10'h084
`define HCSR_OFF_TMR_CONFIG   10'h08C
`define HCSR_OFF_TMR_COUNT    10'h090
`define HCSR_OFF_FREE_RUN     10'h09C
`define HCSR_OFF_RESET_CONTROL    10'h1F8
`define HCSR_OFF_CSR_DATA     10'h300
`define HCSR_OFF_CSR_CMD      10'h304
`define HCSR_OFF_RD_ADDR_LEN  10'h308
`define HCSR_OFF_RD_CMD       10'h30C
`define HCSR_OFF_WR_ADDR_LEN  10'h310
`define HCSR_OFF_WR_CMD       10'h314

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define HCSR_HW_READY_BIT     27
`define HCSR_PMT_READY_BIT    0
`define HCSR_GPT_EN_BIT       29
`define HCSR_GPT_LOAD_MSB     15

// ------------------------------------------------------------------
// Reset values and fixed read values
// ------------------------------------------------------------------
`define HCSR_RST_RW           32'h0000_0000
`define HCSR_RST_INTR_STATUS  32'h0000_0000
`define HCSR_RST_COUNT        32'h0000_0000
`define HCSR_BYTE_TEST_BAD    32'h0000_0000
`define HCSR_BYTE_TEST_GOOD   32'h0403_0201
`define HCSR_ID_VALUE         32'h0000_A5A5

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define HCSR_CLK_PERIOD_NS    4
`define HCSR_TICK_PERIOD_NS   40
`define HCSR_TICK_CYCLES      (`HCSR_TICK_PERIOD_NS / `HCSR_CLK_PERIOD_NS)
`define HCSR_HIF_RESET_CYCLES 64
`define HCSR_READY_CYCLES     256

`endif

/* hw/hcsr_pkg.sv */
// Types shared by the host register map modules.
package hcsr_pkg;
  typedef enum logic [3:0] {
    SEL_NONE      = 4'h0,
    SEL_RD_FIFO   = 4'h1,
    SEL_WR_FIFO   = 4'h2,
    SEL_ID        = 4'h3,
    SEL_INTR_STAT = 4'h4,
    SEL_BYTE_TEST = 4'h5,
    SEL_TMR_COUNT = 4'h6,
    SEL_FREE_RUN  = 4'h7,
    SEL_RW        = 4'h8
  } hcsr_sel_t;

  typedef enum logic [1:0] {
    HS_RESET  = 2'b00,
    HS_HIF_UP = 2'b01,
    HS_READY  = 2'b10
  } hcsr_state_t;
endpackage

/* hw/hcsr_mem_if.sv */
// Connection between the register map and its read FIFO storage.
interface hcsr_mem_if #(
  parameter int W  = 32,
  parameter int AW = 4
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0]  wr_data;
  logic [AW-1:0] rd_addr;
  logic [W-1:0]  rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* hw/hcsr_fifo_mem.sv */
// Storage for the process RAM read data FIFO, with registered read data.
module hcsr_fifo_mem #(
  parameter int W  = 32,
  parameter int AW = 4
) (
  input wire logic mclk_in,
  hcsr_mem_if.mem  port
);
  logic [W-1:0] ram [2**AW];

  always_ff @(posedge mclk_in) begin
    if (port.wr_en) begin
      ram[port.wr_addr] <= port.wr_data;
    end
  end

  // Read every cycle; data trails a pointer change by one cycle.
  always_ff @(posedge mclk_in) begin
    port.rd_data <= ram[port.rd_addr];
  end
endmodule

/* verif/hcsr_host_model.sv */
// Host processor model that issues one register access piece at a time.
module hcsr_host_model (
  input  wire logic        clk_in,
  input  wire logic        rd_valid_in,
  input  wire logic [31:0] rdata_in,
  output logic             req_out,
  output logic             write_out,
  output logic [9:0]       addr_out,
  output logic [1:0]       size_out,
  output logic [31:0]      wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;

  realtime last_wr_t;
  realtime last_pop_t;

  initial begin
    req_out    = 1'h0;
    write_out  = 1'h0;
    addr_out   = 10'h000;
    size_out   = 2'h0;
    wdata_out  = 32'h0000_0000;
    last_wr_t  = -1000.0;
    last_pop_t = -1000.0;
  end

  // ----------------------------------------------------------------
  // One access piece
  // ----------------------------------------------------------------
  // Spacing is met by elapsed time, not by dummy reads, so that no extra traffic
  // disturbs the read FIFO. The longest write-to-read figure covers every pair.
  task automatic piece(input logic wr, input logic [9:0] a, input logic [1:0] sz,
                       input logic [31:0] d, output logic [31:0] q);
    logic [2:0] nbytes;
    nbytes = (sz == 2'h0) ? 3'h1 : ((sz == 2'h1) ? 3'h2 : 3'h4);
    q = 32'hXXXX_XXXX;
    if (!wr) begin
      while ($realtime - last_wr_t < 180.0) @(posedge clk_in);
      while ($realtime - last_pop_t < 50.0) @(posedge clk_in);
    end
    @(posedge clk_in);
    req_out   <= 1'h1;
    write_out <= wr;
    addr_out  <= a;
    size_out  <= sz;
    wdata_out <= d;
    @(posedge clk_in);
    req_out   <= 1'h0;
    addr_out  <= ~a;
    wdata_out <= ~d;
    if (wr && ({1'h0, a[1:0]} + nbytes == 3'h4)) last_wr_t = $realtime;
    if (!wr) begin
      // The answer stands for one cycle; take it mid-cycle, away from the launching edge.
      @(negedge clk_in);
      if (rd_valid_in === 1'h1) q = rdata_in;
      if (a < 10'h020 && ({1'h0, a[1:0]} + nbytes == 3'h4)) last_pop_t = $realtime;
    end
  endtask
endmodule

/* verif/host_csr_map_access_timing_tb.sv */
// Self-checking testbench of the host register map.
`include "hcsr_params.svh"
module host_csr_map_access_timing_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk_in;
  logic        rst_in;
  logic        host_req_in;
  logic        host_write_in;
  logic [9:0]  host_addr_in;
  logic [1:0]  host_size_in;
  logic [31:0] host_wdata_in;
  logic        pram_rd_push_in;
  logic [31:0] pram_rd_data_in;
  logic [31:0] int_event_in;
  logic        host_rd_valid_out;
  logic [31:0] host_rdata_out;
  logic        pram_wr_valid_out;
  logic [31:0] pram_wr_data_out;
  logic        pram_rd_full_out;
  int          error_cnt;
  int          n_checks;
  logic [31:0] wr_q[$];
  logic [31:0] q;
  logic [31:0] f;
  logic [9:0]  rw_offs [9] = '{10'h054, 10'h05C, 10'h1F8, 10'h300, 10'h304,
                                10'h308, 10'h30C, 10'h310, 10'h314};

  hcsr_regs #(.HIF_RESET_CYCLES(4), .READY_CYCLES(8)) DUT (
    .mclk_in(mclk_in), .rst_in(rst_in), .host_req_in(host_req_in),
    .host_write_in(host_write_in), .host_addr_in(host_addr_in),
    .host_size_in(host_size_in), .host_wdata_in(host_wdata_in),
    .pram_rd_push_in(pram_rd_push_in), .pram_rd_data_in(pram_rd_data_in),
    .int_event_in(int_event_in), .host_rd_valid_out(host_rd_valid_out),
    .host_rdata_out(host_rdata_out), .pram_wr_valid_out(pram_wr_valid_out),
    .pram_wr_data_out(pram_wr_data_out), .pram_rd_full_out(pram_rd_full_out)
  );

  hcsr_host_model host (
    .clk_in(mclk_in), .rd_valid_in(host_rd_valid_out), .rdata_in(host_rdata_out),
    .req_out(host_req_in), .write_out(host_write_in), .addr_out(host_addr_in),
    .size_out(host_size_in), .wdata_out(host_wdata_in)
  );

  initial begin
    mclk_in = 1'h0;
    forever #2 mclk_in = ~mclk_in;
  end

  always @(negedge mclk_in) if (pram_wr_valid_out === 1'h1) wr_q.push_back(pram_wr_data_out);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] pat(input logic [9:0] off);
    return 32'h3100_5A00 | {22'h00_0000, off};
  endfunction

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    host.piece(1'h1, a, 2'h2, d, q);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    host.piece(1'h0, a, 2'h0 + 2'h2, 32'h0000_0000, q);
    check32(q, exp);
  endtask

  task automatic wrap_up();
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // The first read must land inside the interface reset, so no wait precedes it.
  task automatic t_after_reset();
    @(posedge mclk_in);
    rst_in <= 1'h1;
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'h0;
    rd(10'h064, `HCSR_BYTE_TEST_BAD);
    foreach (rw_offs[i]) rd(rw_offs[i], 32'h0000_0000);
    rd(10'h058, 32'h0000_0000);
    rd(10'h090, 32'h0000_0000);
    rd(10'h064, `HCSR_BYTE_TEST_GOOD);
    rd(10'h074, 32'h0800_0000);
    rd(10'h084, 32'h0000_0001);
  endtask

  task automatic t_map();
    foreach (rw_offs[i]) wr(rw_offs[i], pat(rw_offs[i]));
    wr(10'h074, pat(10'h074));
    wr(10'h084, pat(10'h084));
    wr(10'h050, 32'hFFFF_FFFF);
    wr(10'h064, 32'hFFFF_FFFF);
    wr(10'h060, 32'hFFFF_FFFF);
    wr(10'h3FC, 32'hFFFF_FFFF);
    foreach (rw_offs[i]) rd(rw_offs[i], pat(rw_offs[i]));
    rd(10'h074, pat(10'h074) | 32'h0800_0000);
    rd(10'h084, pat(10'h084) | 32'h0000_0001);
    rd(10'h050, `HCSR_ID_VALUE);
    rd(10'h064, `HCSR_BYTE_TEST_GOOD);
    rd(10'h060, 32'h0000_0000);
    rd(10'h3FC, 32'h0000_0000);
    rd(10'h020, 32'h0000_0000);
  endtask

  task automatic t_narrow();
    for (int b = 0; b < 4; b++) begin
      if (b == 3) rd(10'h054, pat(10'h054));
      host.piece(1'h1, 10'h054 + 10'(b), 2'h0, 32'h4433_2211, q);
    end
    rd(10'h054, 32'h4433_2211);
    host.piece(1'h0, 10'h054, 2'h1, 32'h0000_0000, q);
    check32({16'h0000, q[15:0]}, 32'h0000_2211);
    host.piece(1'h0, 10'h056, 2'h1, 32'h0000_0000, q);
    check32({q[31:16], 16'h0000}, 32'h4433_0000);
    host.piece(1'h1, 10'h05C, 2'h1, 32'hBEEF_CAFE, q);
    host.piece(1'h1, 10'h05E, 2'h1, 32'hBEEF_CAFE, q);
    rd(10'h05C, 32'hBEEF_CAFE);
  endtask

  // Seventeen pushes: the last meets a full FIFO and must not appear on reads.
  task automatic t_fifo();
    for (int i = 0; i < 17; i++) begin
      @(posedge mclk_in);
      pram_rd_push_in <= 1'h1;
      pram_rd_data_in <= 32'hF1F0_0000 + 32'(i);
    end
    @(posedge mclk_in);
    pram_rd_push_in <= 1'h0;
    repeat (2) @(posedge mclk_in);
    check_bit(pram_rd_full_out, 1'h1);
    for (int i = 0; i < 16; i++) rd(10'(4 * (i % 8)), 32'hF1F0_0000 + 32'(i));
    @(posedge mclk_in);
    check_bit(pram_rd_full_out, 1'h0);
    rd(10'h30C, pat(10'h30C));
    wr(10'h020, 32'h0BAD_0000);
    wr(10'h03C, 32'h0BAD_0001);
    wr(10'h02C, 32'h0BAD_0002);
    repeat (2) @(posedge mclk_in);
    check32(32'(wr_q.size()), 32'h0000_0003);
    foreach (wr_q[i]) check32(wr_q[i], 32'h0BAD_0000 + 32'(i));
    rd(10'h314, pat(10'h314));
  endtask

  task automatic t_irq_timer();
    @(posedge mclk_in);
    int_event_in <= 32'h0000_0088;
    @(posedge mclk_in);
    int_event_in <= 32'h0000_0000;
    rd(10'h058, 32'h0000_0088);
    wr(10'h058, 32'h0000_0008);
    rd(10'h058, 32'h0000_0080);
    wr(10'h08C, 32'h0000_0030);
    rd(10'h090, 32'h0000_0030);
    rd(10'h08C, 32'h0000_0030);
    wr(10'h08C, 32'h2000_0030);
    host.piece(1'h0, 10'h090, 2'h2, 32'h0000_0000, q);
    check_bit(q < 32'h0000_0030 && q > 32'h0000_0020, 1'h1);
    host.piece(1'h0, 10'h09C, 2'h2, 32'h0000_0000, f);
    repeat (12) @(posedge mclk_in);
    host.piece(1'h0, 10'h09C, 2'h2, 32'h0000_0000, q);
    check_bit(q > f, 1'h1);
  endtask

  initial begin
    rst_in          = 1'h1;
    pram_rd_push_in = 1'h0;
    pram_rd_data_in = 32'h0000_0000;
    int_event_in    = 32'h0000_0000;
    error_cnt       = 0;
    n_checks        = 0;
    t_after_reset();
    t_map();
    t_narrow();
    t_fifo();
    t_irq_timer();
    repeat (50) @(posedge mclk_in);
    t_after_reset();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge mclk_in);
    error_cnt++;
    $display("[FAIL] %0t ns: run did not finish", $time);
    wrap_up();
  end
endmodule
